// >>> acc_pkg.sv
// Constants shared by the converter control block.
// Assumes a single mclk domain and byte-wide registers.
package acc_pkg;
    // Register offsets
    localparam logic [2:0] OFS_CTRL0 = 3'h0;
    localparam logic [2:0] OFS_CTRL1 = 3'h1;
    localparam logic [2:0] OFS_RES_HI = 3'h2;
    localparam logic [2:0] OFS_RES_LO = 3'h3;
    localparam logic [2:0] OFS_VREF = 3'h4;
    localparam logic [2:0] OFS_PFLAG = 3'h5;
    localparam logic [2:0] OFS_PEN = 3'h6;
    localparam logic [2:0] OFS_IRQC = 3'h7;
    // Field positions
    localparam int B_ON = 0;
    localparam int B_GO = 1;
    localparam int B_CHS_LO = 2;
    localparam int B_PREF_LO = 0;
    localparam int B_NREF = 2;
    localparam int B_CS_LO = 4;
    localparam int B_JUSTIFY = 7;
    localparam int B_CONV_GAIN_LO = 0;
    localparam int B_CMP_GAIN_LO = 2;
    localparam int B_TS_RANGE = 4;
    localparam int B_TS_EN = 5;
    localparam int B_REF_RDY = 6;
    localparam int B_REF_EN = 7;
    localparam int B_DONE_FLAG = 0;
    localparam int B_PERIPHERAL_IRQ_ENABLE = 6;
    localparam int B_GIE = 7;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [9:0] RST_RESULT = 10'h000;
    // Channel codes
    localparam logic [4:0] CH_LAST_PIN = 5'h0B;
    localparam logic [4:0] CH_TEMP = 5'h1D;
    localparam logic [4:0] CH_DAC = 5'h1E;
    localparam logic [4:0] CH_FIXED_REF = 5'h1F;
    // Positive reference codes
    localparam logic [1:0] PREF_SUPPLY = 2'h0;
    localparam logic [1:0] PREF_PIN = 2'h2;
    localparam logic [1:0] PREF_FIXED = 2'h3;
    // Conversion timing in half bit periods, last bit index and first trial code
    localparam logic [4:0] HALF_LAST = 5'h16;
    localparam logic [4:0] HALF_FIRST_BIT = 5'h04;
    localparam logic [3:0] BITS_LAST = 4'h9;
    localparam logic [9:0] TRIAL_MSB = 10'h200;
    // One instruction cycle of mclk periods, for the RC start delay
    localparam logic [2:0] INSTR_CYCLES = 3'h4;
    // Clock select codes
    localparam logic [1:0] CS_RC_LOW = 2'h3;
    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_WAIT_RC,
        ACC_RUN
    } acc_state_e;
endpackage

// >>> acc_conv_if.sv
// Link between the control registers, the divider and the sequencer.
// Assumes all three sit on mclk.
`timescale 1ns/10ps
`default_nettype none
interface acc_conv_if;
    logic start;
    logic stop;
    logic half_tick;
    logic busy;
    logic done;
    logic aborted;
    logic [9:0] result;
    logic [9:0] trial;
    logic [2:0] clk_sel;
    modport ctl (output start, stop, clk_sel, input busy, done, aborted, result, trial);
    modport tick (input busy, clk_sel, output half_tick);
    modport sar (input start, stop, half_tick, output busy, done, aborted, result, trial);
endinterface
`default_nettype wire

// >>> acc_tick.sv
// Conversion clock: half bit period ticks from mclk or the RC clock.
// Assumes rc_clk_in is sampled synchronously to mclk.
`timescale 1ns/10ps
`default_nettype none
module acc_tick (
    input wire logic mclk,
    input wire logic reset,
    input wire logic rc_clk_in,
    acc_conv_if.tick conv
);
    logic [4:0] cnt_r;
    logic [4:0] half_m1;
    logic rc_prev_r;
    logic rc_sel;

    // Divide 2,4,8,16,32,64: half period of 1..32 mclk
    always_comb begin
        rc_sel = (conv.clk_sel[1:0] == acc_pkg::CS_RC_LOW);
        case (conv.clk_sel)
            3'h0: half_m1 = 5'h00;
            3'h4: half_m1 = 5'h01;
            3'h1: half_m1 = 5'h03;
            3'h5: half_m1 = 5'h07;
            3'h2: half_m1 = 5'h0F;
            3'h6: half_m1 = 5'h1F;
            default: half_m1 = 5'h00;
        endcase
    end

    // Divider runs only during a conversion
    always_ff @(posedge mclk) begin
        if (reset || !conv.busy || cnt_r == half_m1) begin
            cnt_r <= 5'h00;
        end else begin
            cnt_r <= cnt_r + 5'h01;
        end
    end

    // RC clock edge tracking
    always_ff @(posedge mclk) begin
        if (reset) begin
            rc_prev_r <= 1'b0;
        end else begin
            rc_prev_r <= rc_clk_in;
        end
    end

    // Each RC edge or divider wrap is one half bit period
    assign conv.half_tick = conv.busy &&
        (rc_sel ? (rc_clk_in != rc_prev_r) : (cnt_r == half_m1));
endmodule
`default_nettype wire

// >>> acc_sar.sv
// Successive approximation sequencer, one decision per bit period.
// Assumes cmp_in is high while the input stands at or above the trial code.
`timescale 1ns/10ps
`default_nettype none
module acc_sar (
    input wire logic mclk,
    input wire logic reset,
    input wire logic cmp_in,
    acc_conv_if.sar conv
);
    logic busy_r;
    logic [4:0] half_r;
    logic [3:0] dec_r;
    logic [9:0] code_r;
    logic last_bit_r;
    logic done_r;
    logic aborted_r;
    logic [9:0] result_r;
    logic [9:0] undecided;
    logic decide;

    // Bits not yet decided, for filling a partial result
    genvar gi;
    generate
        for (gi = 0; gi < 10; gi++) begin : g_fill
            assign undecided[gi] = (32'(gi) + {28'h0, dec_r}) < 32'd10;
        end
    endgenerate

    assign decide = conv.half_tick && half_r >= acc_pkg::HALF_FIRST_BIT && !half_r[0];

    // Sequence of 23 half bit periods
    always_ff @(posedge mclk) begin
        if (reset) begin
            busy_r <= 1'b0;
            half_r <= 5'h00;
            dec_r <= 4'h0;
            code_r <= acc_pkg::RST_RESULT;
            last_bit_r <= 1'b0;
        end else if (conv.start) begin
            busy_r <= 1'b1;
            half_r <= 5'h00;
            dec_r <= 4'h0;
            code_r <= acc_pkg::TRIAL_MSB;
            last_bit_r <= 1'b0; // No stale fill from an earlier conversion
        end else if (busy_r && conv.stop) begin
            busy_r <= 1'b0;
        end else if (conv.half_tick) begin
            half_r <= half_r + 5'h01;
            if (decide) begin
                code_r[4'd9 - dec_r] <= cmp_in;
                if (dec_r != acc_pkg::BITS_LAST) begin
                    code_r[4'd8 - dec_r] <= 1'b1;
                end
                last_bit_r <= cmp_in;
                dec_r <= dec_r + 4'h1;
            end
            if (half_r == acc_pkg::HALF_LAST) begin
                busy_r <= 1'b0;
            end
        end
    end

    // Result and one-cycle completion or abort pulses
    always_ff @(posedge mclk) begin
        if (reset) begin
            done_r <= 1'b0;
            aborted_r <= 1'b0;
            result_r <= acc_pkg::RST_RESULT;
        end else begin
            done_r <= busy_r && !conv.stop && conv.half_tick && half_r == acc_pkg::HALF_LAST;
            aborted_r <= busy_r && conv.stop && !conv.start;
            if (busy_r && conv.stop) begin
                result_r <= (code_r & ~undecided) | (last_bit_r ? undecided : 10'h000);
            end else if (busy_r && conv.half_tick && half_r == acc_pkg::HALF_LAST) begin
                result_r <= {code_r[9:1], cmp_in};
            end
        end
    end

    assign conv.busy = busy_r;
    assign conv.done = done_r;
    assign conv.aborted = aborted_r;
    assign conv.result = result_r;
    assign conv.trial = code_r;

    a_sar_length: assert property (@(posedge mclk) disable iff (reset)
        conv.done |-> $past(half_r) == acc_pkg::HALF_LAST && dec_r == 4'hA)
        else $error("conversion ended at wrong bit period");
endmodule
`default_nettype wire

// >>> acc_top.sv
// Converter control: registers, start sequencing, result, wake logic.
// Assumes a plain register port with read data one cycle after the strobe.
`timescale 1ns/10ps
`default_nettype none
module acc_top (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic cmp_in,
    input wire logic rc_clk_in,
    input wire logic sleep_mode,
    input wire logic ref_ready_in,
    output logic [4:0] channel_select,
    output logic analog_pin_sel,
    output logic temp_to_converter,
    output logic dac_to_converter,
    output logic fixed_ref_to_converter,
    output logic sample_connect,
    output logic [9:0] trial_code,
    output logic [1:0] positive_ref_select,
    output logic negative_ref_select,
    output logic reference_enable,
    output logic [1:0] converter_ref_gain,
    output logic [1:0] cmp_dac_ref_gain,
    output logic temp_sense_power,
    output logic temp_range_high,
    output logic irq_request,
    output logic wake_request,
    output logic vector_to_isr
);
    acc_conv_if conv ();

    logic [7:0] ctrl0_r;
    logic [7:0] ctrl1_r;
    logic [7:0] vref_r;
    logic [7:0] result_high_r;
    logic [7:0] result_low_r;
    logic [7:0] rdata_r;
    logic done_flag_r;
    logic done_irq_en_r;
    logic global_irq_enable_r;
    logic peripheral_irq_enable_r;
    logic [2:0] wait_r;
    acc_pkg::acc_state_e state_r;
    logic go_r;
    logic converter_on;
    logic rc_sel;
    logic wr_ctrl0;
    logic go_req;
    logic go_clear_req;
    logic wait_end;
    logic abort_req;

    acc_tick u_tick (
        .mclk(mclk),
        .reset(reset),
        .rc_clk_in(rc_clk_in),
        .conv(conv.tick)
    );

    acc_sar u_sar (
        .mclk(mclk),
        .reset(reset),
        .cmp_in(cmp_in),
        .conv(conv.sar)
    );

    // Decoded control fields
    assign converter_on = ctrl0_r[acc_pkg::B_ON];
    assign go_r = ctrl0_r[acc_pkg::B_GO];
    assign rc_sel = ctrl1_r[acc_pkg::B_CS_LO +: 2] == acc_pkg::CS_RC_LOW;
    assign wr_ctrl0 = wr_en && addr == acc_pkg::OFS_CTRL0;
    // Go only counts if the converter was already on
    assign go_req = wr_ctrl0 && wdata[acc_pkg::B_GO] && converter_on &&
        state_r == acc_pkg::ACC_IDLE;
    assign go_clear_req = wr_ctrl0 && !wdata[acc_pkg::B_GO] && go_r;
    assign wait_end = state_r == acc_pkg::ACC_WAIT_RC &&
        wait_r == acc_pkg::INSTR_CYCLES - 3'h1;
    // Sleep stops a conversion unless it runs on the RC clock
    assign abort_req = go_clear_req || !converter_on || (sleep_mode && !rc_sel);

    // Start pulse to the sequencer, delayed on RC clock
    assign conv.start = (go_req && !rc_sel) || (wait_end && !abort_req);
    assign conv.stop = state_r == acc_pkg::ACC_RUN && abort_req;
    assign conv.clk_sel = ctrl1_r[acc_pkg::B_CS_LO +: 3];

    // Start sequencing
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_r <= acc_pkg::ACC_IDLE;
        end else begin
            case (state_r)
                acc_pkg::ACC_IDLE: begin
                    if (go_req) begin
                        state_r <= rc_sel ? acc_pkg::ACC_WAIT_RC : acc_pkg::ACC_RUN;
                    end
                end
                acc_pkg::ACC_WAIT_RC: begin
                    if (abort_req) begin
                        state_r <= acc_pkg::ACC_IDLE;
                    end else if (wait_end) begin
                        state_r <= acc_pkg::ACC_RUN;
                    end
                end
                acc_pkg::ACC_RUN: begin
                    if (conv.done || conv.aborted) begin
                        state_r <= acc_pkg::ACC_IDLE;
                    end
                end
                default: state_r <= acc_pkg::ACC_IDLE;
            endcase
        end
    end

    // One instruction cycle counter for the RC start delay
    always_ff @(posedge mclk) begin
        if (reset || state_r != acc_pkg::ACC_WAIT_RC) begin
            wait_r <= 3'h0;
        end else begin
            wait_r <= wait_r + 3'h1;
        end
    end

    // Control register 0: channel, go and enable
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl0_r <= acc_pkg::RST_BYTE;
        end else begin
            if (wr_ctrl0) begin
                ctrl0_r[6:0] <= wdata[6:0];
                ctrl0_r[acc_pkg::B_GO] <= go_req || (go_r && wdata[acc_pkg::B_GO]);
            end
            if (conv.done || conv.aborted ||
                (state_r == acc_pkg::ACC_WAIT_RC && abort_req)) begin
                ctrl0_r[acc_pkg::B_GO] <= 1'b0;
            end
        end
    end

    // Control register 1 and reference control
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl1_r <= acc_pkg::RST_BYTE;
            vref_r <= acc_pkg::RST_BYTE;
        end else if (wr_en && addr == acc_pkg::OFS_CTRL1) begin
            ctrl1_r <= wdata & 8'hF7;
        end else if (wr_en && addr == acc_pkg::OFS_VREF) begin
            vref_r <= wdata & 8'hBF;
        end
    end

    // Result pair: loaded on completion or abort, else held
    always_ff @(posedge mclk) begin
        if (reset) begin
            result_high_r <= acc_pkg::RST_BYTE;
            result_low_r <= acc_pkg::RST_BYTE;
        end else if (conv.done || conv.aborted) begin
            if (ctrl1_r[acc_pkg::B_JUSTIFY]) begin
                result_high_r <= {6'h00, conv.result[9:8]};
                result_low_r <= conv.result[7:0];
            end else begin
                result_high_r <= conv.result[9:2];
                result_low_r <= {conv.result[1:0], 6'h00};
            end
        end
    end

    // Done flag: set wins over a software clear
    always_ff @(posedge mclk) begin
        if (reset) begin
            done_flag_r <= 1'b0;
        end else if (conv.done) begin
            done_flag_r <= 1'b1;
        end else if (wr_en && addr == acc_pkg::OFS_PFLAG) begin
            done_flag_r <= wdata[acc_pkg::B_DONE_FLAG];
        end
    end

    // Interrupt enables
    always_ff @(posedge mclk) begin
        if (reset) begin
            done_irq_en_r <= 1'b0;
            global_irq_enable_r <= 1'b0;
            peripheral_irq_enable_r <= 1'b0;
        end else if (wr_en && addr == acc_pkg::OFS_PEN) begin
            done_irq_en_r <= wdata[acc_pkg::B_DONE_FLAG];
        end else if (wr_en && addr == acc_pkg::OFS_IRQC) begin
            global_irq_enable_r <= wdata[acc_pkg::B_GIE];
            peripheral_irq_enable_r <= wdata[acc_pkg::B_PERIPHERAL_IRQ_ENABLE];
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (reset || !rd_en) begin
            rdata_r <= acc_pkg::RST_BYTE;
        end else begin
            case (addr)
                acc_pkg::OFS_CTRL0: rdata_r <= ctrl0_r;
                acc_pkg::OFS_CTRL1: rdata_r <= ctrl1_r;
                acc_pkg::OFS_RES_HI: rdata_r <= result_high_r;
                acc_pkg::OFS_RES_LO: rdata_r <= result_low_r;
                acc_pkg::OFS_VREF: rdata_r <= vref_r | {1'b0,
                    vref_r[acc_pkg::B_REF_EN] && ref_ready_in, 6'h00};
                acc_pkg::OFS_PFLAG: rdata_r <= {7'h00, done_flag_r};
                acc_pkg::OFS_PEN: rdata_r <= {7'h00, done_irq_en_r};
                acc_pkg::OFS_IRQC: rdata_r <= {global_irq_enable_r,
                    peripheral_irq_enable_r, 6'h00};
                default: rdata_r <= acc_pkg::RST_BYTE;
            endcase
        end
    end
    assign rdata = rdata_r;

    // Input selection toward the sample and hold
    assign channel_select = ctrl0_r[acc_pkg::B_CHS_LO +: 5];
    assign analog_pin_sel = channel_select <= acc_pkg::CH_LAST_PIN;
    assign temp_to_converter = channel_select == acc_pkg::CH_TEMP;
    assign dac_to_converter = channel_select == acc_pkg::CH_DAC;
    assign fixed_ref_to_converter = channel_select == acc_pkg::CH_FIXED_REF;
    // Track the input while idle, hold it while converting
    assign sample_connect = converter_on && !conv.busy;
    assign trial_code = conv.trial;

    // References and temperature sensor
    assign positive_ref_select = ctrl1_r[acc_pkg::B_PREF_LO +: 2];
    assign negative_ref_select = ctrl1_r[acc_pkg::B_NREF];
    assign reference_enable = vref_r[acc_pkg::B_REF_EN];
    assign converter_ref_gain = vref_r[acc_pkg::B_CONV_GAIN_LO +: 2];
    assign cmp_dac_ref_gain = vref_r[acc_pkg::B_CMP_GAIN_LO +: 2];
    assign temp_sense_power = vref_r[acc_pkg::B_TS_EN];
    assign temp_range_high = vref_r[acc_pkg::B_TS_RANGE];

    // Interrupt, wake and resume decision
    assign irq_request = done_flag_r && done_irq_en_r;
    assign wake_request = sleep_mode && irq_request;
    assign vector_to_isr = irq_request && global_irq_enable_r && peripheral_irq_enable_r;

    a_flag_on_done: assert property (@(posedge mclk) disable iff (reset)
        conv.done |=> done_flag_r && !go_r)
        else $error("done did not set flag or clear go");
    a_flag_sticky: assert property (@(posedge mclk) disable iff (reset)
        done_flag_r && !(wr_en && addr == acc_pkg::OFS_PFLAG) |=> done_flag_r)
        else $error("done flag cleared without software");
    a_right_zero: assert property (@(posedge mclk) disable iff (reset)
        conv.done && ctrl1_r[acc_pkg::B_JUSTIFY] |=>
        result_high_r[7:2] == 6'h00 && result_low_r == $past(conv.result[7:0]))
        else $error("right justified load wrong");
    a_left_zero: assert property (@(posedge mclk) disable iff (reset)
        conv.done && !ctrl1_r[acc_pkg::B_JUSTIFY] |=>
        result_low_r[5:0] == 6'h00 && result_high_r == $past(conv.result[9:2]))
        else $error("left justified load wrong");
    a_result_hold: assert property (@(posedge mclk) disable iff (reset)
        !conv.done && !conv.aborted |=> $stable(result_high_r) && $stable(result_low_r))
        else $error("result changed without a load");
    a_irq_gate: assert property (@(posedge mclk) disable iff (reset)
        irq_request |-> done_flag_r && done_irq_en_r)
        else $error("interrupt request not gated by enable");
    a_sleep_abort: assert property (@(posedge mclk) disable iff (reset)
        conv.busy && sleep_mode && !rc_sel |=> !conv.busy ##1 !go_r)
        else $error("conversion ran in sleep off RC clock");
    a_rc_delay: assert property (@(posedge mclk) disable iff (reset)
        go_req && rc_sel |-> !conv.start ##1 !conv.start [*3])
        else $error("RC start not delayed");
    a_go_start: assert property (@(posedge mclk) disable iff (reset)
        go_req && !rc_sel |=> go_r && conv.busy)
        else $error("go write did not start");
    a_temp_route: assert property (@(posedge mclk) disable iff (reset)
        temp_to_converter |-> ctrl0_r[6:2] == 5'h1D && !analog_pin_sel)
        else $error("temperature channel misrouted");
endmodule
`default_nettype wire

// >>> acc_ana_model.sv
// Analog side model: comparator facing the sequencer's trial code.
// Assumes the level input holds the sampled input as a ten-bit code.
`timescale 1ns/10ps
`default_nettype none
module acc_ana_model (
    input wire logic [9:0] level,
    input wire logic [9:0] trial_code,
    output logic cmp_in
);
    // High while the sampled input sits at or above the trial code
    assign cmp_in = (level >= trial_code);
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the converter control block.
// Assumes a 40 MHz mclk and the plain register port of the top module.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic mclk, reset, wr_en, rd_en, rc_clk_in, sleep_mode, ref_ready_in, cmp_in;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, d;
    logic [9:0] level, trial_code;
    logic [4:0] channel_select;
    logic [1:0] positive_ref_select, converter_ref_gain, cmp_dac_ref_gain;
    logic analog_pin_sel, temp_to_converter, dac_to_converter, fixed_ref_to_converter;
    logic sample_connect, negative_ref_select, reference_enable, temp_sense_power;
    logic temp_range_high, irq_request, wake_request, vector_to_isr;
    int errors = 0, checked = 0, cyc = 0, n;

    acc_top uut (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .cmp_in(cmp_in), .rc_clk_in(rc_clk_in),
        .sleep_mode(sleep_mode), .ref_ready_in(ref_ready_in),
        .channel_select(channel_select), .analog_pin_sel(analog_pin_sel),
        .temp_to_converter(temp_to_converter), .dac_to_converter(dac_to_converter),
        .fixed_ref_to_converter(fixed_ref_to_converter), .sample_connect(sample_connect),
        .trial_code(trial_code), .positive_ref_select(positive_ref_select),
        .negative_ref_select(negative_ref_select), .reference_enable(reference_enable),
        .converter_ref_gain(converter_ref_gain), .cmp_dac_ref_gain(cmp_dac_ref_gain),
        .temp_sense_power(temp_sense_power), .temp_range_high(temp_range_high),
        .irq_request(irq_request), .wake_request(wake_request), .vector_to_isr(vector_to_isr));
    acc_ana_model ana (.level(level), .trial_code(trial_code), .cmp_in(cmp_in));

    // Clock source
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // RC clock stand-in and hang limit
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (reset) rc_clk_in <= 1'b0;
        else if (cyc % 3 == 0) rc_clk_in <= ~rc_clk_in;
        if (cyc == 30000) begin
            errors++;
            print_verdict;
        end
    end
    task print_verdict;
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a; wdata <= v; wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
        #1;
    endtask
    task rd(input logic [2:0] a);
        @(posedge mclk);
        addr <= a; rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask
    // Start a conversion, count cycles until the sampler reconnects
    task conv(input logic [7:0] c1, input logic [9:0] v);
        level <= v;
        wr(3'h1, c1); // Clock chosen for a legal bit period
        wr(3'h0, 8'h05); // Channel settles before go
        wr(3'h0, 8'h07);
        n = 0;
        do begin
            @(posedge mclk); #1; n++;
        end while ((sample_connect !== 1'b1 || n < 8) && n < 4000);
        // Let the done pulse land in flag, go and result
        @(posedge mclk); #1;
    endtask
    task res(input logic j, input logic [9:0] v);
        rd(3'h2); chk(d, j ? {6'h00, v[9:8]} : v[9:2]);
        rd(3'h3); chk(d, j ? v[7:0] : {v[1:0], 6'h00});
        rd(3'h0); chk(d[1], 1'b0);
    endtask
    task t_reset;
        for (int i = 0; i < 8; i++) begin
            rd(i[2:0]); chk(d, 8'h00);
        end
        chk(analog_pin_sel, 1'b1);
        $display("test reset done");
    endtask
    task t_chan;
        logic [4:0] cs [6] = '{5'h00, 5'h0B, 5'h0C, 5'h1D, 5'h1E, 5'h1F};
        for (int i = 0; i < 6; i++) begin
            wr(3'h0, {1'b1, cs[i], 2'h1});
            rd(3'h0); chk(d, {1'b0, cs[i], 2'h1});
            chk(channel_select, cs[i]);
            chk(analog_pin_sel, cs[i] <= 5'h0B);
            chk(temp_to_converter, cs[i] == 5'h1D);
            chk({dac_to_converter, fixed_ref_to_converter}, {cs[i] == 5'h1E, cs[i] == 5'h1F});
        end
        $display("test channel done");
    endtask
    task t_ref;
        @(posedge mclk);
        ref_ready_in <= 1'b1;
        wr(3'h1, 8'h07); chk({positive_ref_select, negative_ref_select}, 3'h7);
        wr(3'h1, 8'h0A); rd(3'h1); chk(d, 8'h02);
        wr(3'h4, 8'hB6); rd(3'h4); chk(d, 8'hF6);
        chk({reference_enable, temp_sense_power, temp_range_high}, 3'h7);
        chk({cmp_dac_ref_gain, converter_ref_gain}, 4'h6);
        wr(3'h4, 8'h40); rd(3'h4); chk(d, 8'h00);
        chk({temp_sense_power, temp_range_high}, 2'h0);
        $display("test reference done");
    endtask
    task t_div;
        logic [2:0] cs [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
        logic [9:0] v;
        for (int i = 0; i < 6; i++) begin
            v = 10'h2A5 ^ (i * 10'h07B);
            conv({i[0], cs[i], 4'h0}, v);
            chk(n >= 23 * (1 << i) && n <= 24 * (1 << i) + 4, 1'b1);
            res(i[0], v);
            rd(3'h5); chk(d, 8'h01);
            wr(3'h5, 8'h00); // Software clears the flag
        end
        $display("test divider done");
    endtask
    task t_irq;
        wr(3'h6, 8'h00);
        conv(8'h80, 10'h3C3);
        chk(irq_request, 1'b0);
        rd(3'h5); chk(d, 8'h01);
        wr(3'h6, 8'h01); chk({irq_request, wake_request, vector_to_isr}, 3'h4);
        wr(3'h7, 8'hC0); chk(vector_to_isr, 1'b1);
        level <= 10'h000;
        repeat (30) @(posedge mclk);
        res(1'b1, 10'h3C3);
        wr(3'h5, 8'h00); chk(irq_request, 1'b0);
        wr(3'h7, 8'h00);
        $display("test interrupt done");
    endtask
    task t_sleep;
        wr(3'h1, 8'hE0); wr(3'h0, 8'h05); wr(3'h0, 8'h07);
        repeat (40) @(posedge mclk);
        sleep_mode <= 1'b1;
        repeat (8) @(posedge mclk);
        rd(3'h0); chk(d[1], 1'b0);
        rd(3'h5); chk(d, 8'h00);
        res(1'b1, 10'h000);
        conv(8'hB0, 10'h155);
        chk(wake_request, 1'b1);
        res(1'b1, 10'h155);
        @(posedge mclk);
        sleep_mode <= 1'b0;
        $display("test sleep done");
    endtask

    // Main sequence
    initial begin
        reset = 1'b1; wr_en = 1'b0; rd_en = 1'b0; addr = 3'h0; wdata = 8'h00;
        sleep_mode = 1'b0; ref_ready_in = 1'b0; level = 10'h000;
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        t_reset;
        t_chan;
        t_ref;
        t_div;
        t_irq;
        t_sleep;
        print_verdict;
    end
endmodule
`default_nettype wire
